// file: verilog/wqcf_pkg.sv
// Shared constants, types and helpers for the queue configuration fields
`default_nettype none
package wqcf_pkg;

  // Register byte offsets inside the queue configuration block
  localparam logic [4:0]  OFS_MODE_XLAT  = 5'h08;
  localparam logic [4:0]  OFS_SIZE_LIM   = 5'h0C;
  localparam logic [4:0]  OFS_IRQ_ROUTE  = 5'h10;

  // Field positions
  localparam int unsigned POS_MODE       = 0;
  localparam int unsigned POS_BOF_EN     = 1;
  localparam int unsigned POS_ATS_DIS    = 2;
  localparam int unsigned POS_PRS_DIS    = 3;
  localparam int unsigned POS_XFER_LO    = 0;
  localparam int unsigned POS_XFER_HI    = 4;
  localparam int unsigned POS_BATCH_LO   = 5;
  localparam int unsigned POS_BATCH_HI   = 8;
  localparam int unsigned POS_HANDLE_LO  = 0;
  localparam int unsigned POS_HANDLE_HI  = 15;
  localparam int unsigned POS_TBL_SEL    = 16;

  // Reset values
  localparam logic        RST_MODE       = 1'h0;
  localparam logic        RST_BOF_EN     = 1'h0;
  localparam logic        RST_ATS_DIS    = 1'h0;
  localparam logic        RST_PRS_DIS    = 1'h0;
  localparam logic [4:0]  RST_XFER       = 5'h00;
  localparam logic [3:0]  RST_BATCH      = 4'h0;
  localparam logic        RST_TBL_SEL    = 1'h0;
  localparam logic [15:0] RST_HANDLE     = 16'h0000;

  // Queue state codes as software sees them
  localparam logic [1:0]  QSTATE_DISABLED = 2'h0;
  localparam logic [1:0]  QSTATE_ENABLED  = 2'h1;
  localparam logic [1:0]  QSTATE_DRAINING = 2'h2;

  // Enable check result codes
  localparam logic [1:0]  CHK_NONE       = 2'h0;
  localparam logic [1:0]  CHK_XFER_BAD   = 2'h1;
  localparam logic [1:0]  CHK_BATCH_BAD  = 2'h2;

  typedef enum {
    ST_DISABLED,
    ST_CHECKING,
    ST_ENABLED,
    ST_DRAINING
  } wqcf_state_t;

  // True when value is at most two raised to n
  function automatic logic wqcf_within_pow2(input logic [31:0] value,
                                            input logic [4:0]  n);
    return {1'h0, value} <= (33'h1 << n);
  endfunction

endpackage
`default_nettype wire

// file: verilog/wqcf_enable_check.sv
// Size limit checks run when the queue is enabled
`timescale 1ns/1ns
`default_nettype none
module wqcf_enable_check
  import wqcf_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  // Check request
  input  wire logic       check_start,
  // Programmed fields and device limits
  input  wire logic       batch_supported,
  input  wire logic [3:0] batch_field,
  input  wire logic [3:0] batch_max_sup,
  input  wire logic [4:0] xfer_field,
  input  wire logic [4:0] xfer_max_sup,
  // Result
  output logic            check_done,
  output logic            check_ok,
  output logic [1:0]      check_err
);

  logic xfer_bad;
  logic batch_bad;

  assign xfer_bad  = xfer_field > xfer_max_sup; // R13
  assign batch_bad = batch_supported &&
                     (batch_field == 4'h0 || batch_field > batch_max_sup); // R12

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      check_done <= 1'h0;
      check_ok   <= 1'h0;
      check_err  <= CHK_NONE;
    end else begin
      check_done <= check_start;
      if (check_start) begin
        check_ok  <= !xfer_bad && !batch_bad;
        check_err <= xfer_bad ? CHK_XFER_BAD :
                     batch_bad ? CHK_BATCH_BAD : CHK_NONE;
      end
    end
  end

endmodule
`default_nettype wire

// file: verilog/wqcf_desc_policy.sv
// Per-descriptor translation, fault and size decisions
`timescale 1ns/1ns
`default_nettype none
module wqcf_desc_policy
  import wqcf_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Descriptor in
  input  wire logic        desc_valid,
  input  wire logic        desc_bof_flag,
  input  wire logic        desc_is_batch,
  input  wire logic [31:0] desc_xfer_size,
  input  wire logic [15:0] desc_batch_count,
  // Queue settings in effect
  input  wire logic        queue_enabled,
  input  wire logic        ats_allowed,
  input  wire logic        prs_allowed,
  input  wire logic        bof_allowed,
  input  wire logic [4:0]  xfer_limit,
  input  wire logic [3:0]  batch_limit,
  // Decision out
  output logic             res_valid,
  output logic             res_refused,
  output logic             res_use_ats,
  output logic             res_fault_block,
  output logic             res_size_ok
);

  logic block_d;
  logic size_ok_d;

  // Flag is ignored unless the queue allows blocking
  assign block_d = prs_allowed && bof_allowed && desc_bof_flag; // R1 R7 R8
  assign size_ok_d = wqcf_within_pow2(desc_xfer_size, xfer_limit) && // R13
    (!desc_is_batch ||
     wqcf_within_pow2(32'(desc_batch_count), 5'(batch_limit))); // R11

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      res_valid       <= 1'h0;
      res_refused     <= 1'h0;
      res_use_ats     <= 1'h0;
      res_fault_block <= 1'h0;
      res_size_ok     <= 1'h0;
    end else begin
      res_valid <= desc_valid;
      if (desc_valid) begin
        res_refused     <= !queue_enabled; // R20
        res_use_ats     <= ats_allowed; // R5
        res_fault_block <= block_d;
        res_size_ok     <= size_ok_d;
      end
    end
  end

endmodule
`default_nettype wire

// file: verilog/wqcf_top.sv
// Queue configuration fields, queue state and their effects
//
// Rules the document sets for this block
// R1: PRS used per PCIe enable, BOF settings
// R2: PRS disable set: never issue page requests
// R3: No PRS support: disable bit reads zero
// R4: Software keeps PRS disable zero without log
// R5: ATS disable set overrides PCIe ATS enable
// R6: No ATS support: disable bit reads zero
// R7: BOF off: flag ignored, faults stop, report
// R8: BOF on: descriptor flag picks fault handling
// R9: BOF enable reserved without support or PRS
// R10: Mode bit: zero shared, one dedicated
// R11: Batch count limited to two power field
// R12: Batch field nonzero, within max, checked
// R13: Transfer size limited, field checked at enable
// R14: Software picks smallest size limits needed
// R15: Table bit: zero MSI-X, one message store
// R16: Table bit and handle locked unless Disabled
// R17: Software keeps table bit zero without INTERRUPT_MESSAGE_STORE
// R18: No occupancy interrupt: route fields reserved
// R19: Handle is index or requested handle
// R20: State reads 00 Disabled, 01 Enabled
// R21: Locked writes ignored; reads show values
`timescale 1ns/1ns
`default_nettype none
module wqcf_top
  import wqcf_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Register access, full 32-bit words
  input  wire logic [4:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Device capabilities
  input  wire logic        cap_prs_support,
  input  wire logic        cap_ats_support,
  input  wire logic        cap_bof_support,
  input  wire logic        cap_batch_support,
  input  wire logic [3:0]  cap_batch_max,
  input  wire logic [4:0]  cap_xfer_max,
  input  wire logic        cap_occ_irq_support,
  input  wire logic        cap_handle_request,
  // PCIe capability enables
  input  wire logic        pcie_prs_enable,
  input  wire logic        pcie_ats_enable,
  // Queue commands
  input  wire logic        enable_cmd,
  input  wire logic        disable_cmd,
  input  wire logic        drain_done,
  // Queue state
  output logic [1:0]       queue_state,
  output logic             enable_error,
  output logic [1:0]       enable_error_code,
  // Settings in effect
  output logic             queue_dedicated,
  output logic             use_ats,
  output logic             use_prs,
  output logic [4:0]       xfer_limit,
  output logic [3:0]       batch_limit,
  output logic             occ_irq_table_select,
  output logic [15:0]      occ_irq_handle,
  output logic             occ_irq_handle_direct,
  // Descriptor decisions
  input  wire logic        desc_valid,
  input  wire logic        desc_bof_flag,
  input  wire logic        desc_is_batch,
  input  wire logic [31:0] desc_xfer_size,
  input  wire logic [15:0] desc_batch_count,
  output logic             res_valid,
  output logic             res_refused,
  output logic             res_use_ats,
  output logic             res_fault_block,
  output logic             res_size_ok,
  // Page faults from the engine
  input  wire logic        page_fault,
  input  wire logic        page_fault_blocking,
  output logic             fault_stop_report,
  output logic             fault_page_request
);

  ////////////////////////////////////////////////////////////////////////////
  // Stored fields

  logic        mode_q;
  logic        bof_en_q;
  logic        ats_dis_q;
  logic        prs_dis_q;
  logic [4:0]  xfer_q;
  logic [3:0]  batch_q;
  logic        tbl_sel_q;
  logic [15:0] handle_q;

  wqcf_state_t state_q;
  wqcf_state_t state_d;

  logic        err_q;
  logic [1:0]  err_code_q;

  ////////////////////////////////////////////////////////////////////////////
  // Lock and write decode

  logic lock_open;
  logic hit_mode;
  logic hit_size;
  logic hit_route;
  logic wr_mode;
  logic wr_size;
  logic wr_route;

  // Every field here is held while the queue is anywhere but Disabled
  assign lock_open = (state_q == ST_DISABLED); // R16 R21
  assign hit_mode  = (reg_addr == OFS_MODE_XLAT);
  assign hit_size  = (reg_addr == OFS_SIZE_LIM);
  assign hit_route = (reg_addr == OFS_IRQ_ROUTE);
  assign wr_mode   = reg_wr && hit_mode && lock_open; // R21
  assign wr_size   = reg_wr && hit_size && lock_open; // R21
  assign wr_route  = reg_wr && hit_route && lock_open; // R16

  ////////////////////////////////////////////////////////////////////////////
  // Values in effect, reserved bits forced to zero

  logic        prs_dis_eff;
  logic        ats_dis_eff;
  logic        bof_en_eff;
  logic [3:0]  batch_eff;
  logic        tbl_sel_eff;
  logic [15:0] handle_eff;
  logic        prs_allowed;
  logic        ats_allowed;

  assign prs_dis_eff = prs_dis_q && cap_prs_support; // R3
  assign ats_dis_eff = ats_dis_q && cap_ats_support; // R6
  // Also masked by PRS disable so a bad setting cannot block
  assign bof_en_eff  = bof_en_q && cap_bof_support && pcie_prs_enable &&
                       !prs_dis_eff; // R9 R2
  assign batch_eff   = cap_batch_support ? batch_q : 4'h0; // R12
  assign tbl_sel_eff = tbl_sel_q && cap_occ_irq_support; // R18
  assign handle_eff  = cap_occ_irq_support ? handle_q : 16'h0000; // R18
  assign prs_allowed = pcie_prs_enable && !prs_dis_eff; // R1 R2
  assign ats_allowed = pcie_ats_enable && !ats_dis_eff; // R5

  ////////////////////////////////////////////////////////////////////////////
  // Field registers

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q    <= RST_MODE;
      bof_en_q  <= RST_BOF_EN;
      ats_dis_q <= RST_ATS_DIS;
      prs_dis_q <= RST_PRS_DIS;
    end else if (wr_mode) begin
      mode_q    <= reg_wdata[POS_MODE]; // R10
      bof_en_q  <= reg_wdata[POS_BOF_EN] && cap_bof_support; // R9
      ats_dis_q <= reg_wdata[POS_ATS_DIS] && cap_ats_support; // R6
      prs_dis_q <= reg_wdata[POS_PRS_DIS] && cap_prs_support; // R3
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      xfer_q  <= RST_XFER;
      batch_q <= RST_BATCH;
    end else if (wr_size) begin
      xfer_q  <= reg_wdata[POS_XFER_HI:POS_XFER_LO]; // R13
      batch_q <= reg_wdata[POS_BATCH_HI:POS_BATCH_LO]; // R11
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tbl_sel_q <= RST_TBL_SEL;
      handle_q  <= RST_HANDLE;
    end else if (wr_route && cap_occ_irq_support) begin
      tbl_sel_q <= reg_wdata[POS_TBL_SEL]; // R15
      handle_q  <= reg_wdata[POS_HANDLE_HI:POS_HANDLE_LO]; // R19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [31:0] word_mode;
  logic [31:0] word_size;
  logic [31:0] word_route;
  logic [31:0] rd_mux;

  // Reads return what the logic is really using, except the BOF bit, which ignores PRS disable
  assign word_mode  = {28'h0000000, prs_dis_eff, ats_dis_eff,
                       bof_en_q && cap_bof_support && pcie_prs_enable,
                       mode_q}; // R21
  assign word_size  = {23'h000000, batch_eff, xfer_q}; // R21
  assign word_route = {15'h0000, tbl_sel_eff, handle_eff}; // R18
  // Unmapped offsets read zero
  assign rd_mux = hit_mode  ? word_mode  :
                  hit_size  ? word_size  :
                  hit_route ? word_route : 32'h00000000;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable checks

  logic       chk_start;
  logic       chk_done;
  logic       chk_ok;
  logic [1:0] chk_err;

  assign chk_start = (state_q == ST_DISABLED) && enable_cmd;

  wqcf_enable_check u_check (
    .core_clk        (core_clk),
    .arst_n          (arst_n),
    .check_start     (chk_start),
    .batch_supported (cap_batch_support),
    .batch_field     (batch_q),
    .batch_max_sup   (cap_batch_max),
    .xfer_field      (xfer_q),
    .xfer_max_sup    (cap_xfer_max),
    .check_done      (chk_done),
    .check_ok        (chk_ok),
    .check_err       (chk_err)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Queue state machine

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_DISABLED: begin
        if (enable_cmd) begin
          state_d = ST_CHECKING;
        end
      end
      ST_CHECKING: begin
        if (chk_done) begin
          state_d = chk_ok ? ST_ENABLED : ST_DISABLED; // R12 R13
        end
      end
      ST_ENABLED: begin
        if (disable_cmd) begin
          state_d = ST_DRAINING;
        end
      end
      ST_DRAINING: begin
        if (drain_done) begin
          state_d = ST_DISABLED;
        end
      end
      default: begin
        state_d = ST_DISABLED;
      end
    endcase
  end

  logic [1:0] qstate_code;

  // Checking still reports Disabled; descriptors are refused until done
  assign qstate_code = (state_d == ST_ENABLED)  ? QSTATE_ENABLED  :
                       (state_d == ST_DRAINING) ? QSTATE_DRAINING :
                       QSTATE_DISABLED; // R20

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q     <= ST_DISABLED;
      queue_state <= QSTATE_DISABLED;
    end else begin
      state_q     <= state_d;
      queue_state <= qstate_code; // R20
    end
  end

  // Failed check flag; a new enable clears it, a failure sets it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      err_q      <= 1'h0;
      err_code_q <= CHK_NONE;
    end else if (chk_done && !chk_ok) begin
      err_q      <= 1'h1;
      err_code_q <= chk_err;
    end else if (chk_start) begin
      err_q      <= 1'h0;
      err_code_q <= CHK_NONE;
    end
  end

  assign enable_error      = err_q;
  assign enable_error_code = err_code_q;

  ////////////////////////////////////////////////////////////////////////////
  // Settings in effect, registered for the datapath

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      queue_dedicated       <= 1'h0;
      use_ats               <= 1'h0;
      use_prs               <= 1'h0;
      xfer_limit            <= RST_XFER;
      batch_limit           <= RST_BATCH;
      occ_irq_table_select  <= RST_TBL_SEL;
      occ_irq_handle        <= RST_HANDLE;
      occ_irq_handle_direct <= 1'h0;
    end else begin
      queue_dedicated       <= mode_q; // R10
      use_ats               <= ats_allowed; // R5
      use_prs               <= prs_allowed; // R1 R2
      xfer_limit            <= xfer_q; // R13
      batch_limit           <= batch_eff; // R11
      occ_irq_table_select  <= tbl_sel_eff; // R15
      occ_irq_handle        <= handle_eff; // R19
      occ_irq_handle_direct <= !cap_handle_request; // R19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor decisions

  wqcf_desc_policy u_policy (
    .core_clk         (core_clk),
    .arst_n           (arst_n),
    .desc_valid       (desc_valid),
    .desc_bof_flag    (desc_bof_flag),
    .desc_is_batch    (desc_is_batch),
    .desc_xfer_size   (desc_xfer_size),
    .desc_batch_count (desc_batch_count),
    .queue_enabled    (state_q == ST_ENABLED),
    .ats_allowed      (ats_allowed),
    .prs_allowed      (prs_allowed),
    .bof_allowed      (bof_en_eff),
    .xfer_limit       (xfer_q),
    .batch_limit      (batch_eff),
    .res_valid        (res_valid),
    .res_refused      (res_refused),
    .res_use_ats      (res_use_ats),
    .res_fault_block  (res_fault_block),
    .res_size_ok      (res_size_ok)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Page fault handling

  logic fault_wait;

  // A blocking fault is only honoured while page requests are allowed
  assign fault_wait = page_fault_blocking && prs_allowed && bof_en_eff; // R8

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_stop_report  <= 1'h0;
      fault_page_request <= 1'h0;
    end else begin
      fault_stop_report  <= page_fault && !fault_wait; // R7
      fault_page_request <= page_fault && fault_wait; // R1 R2
    end
  end

endmodule
`default_nettype wire

// file: dv/wqcf_top_asserts.sv
// Port assertions for the queue configuration block
`timescale 1ns/1ns
`default_nettype none
module wqcf_top_asserts
  import wqcf_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        arst_n,
  // Queue state and settings
  input wire logic        enable_cmd,
  input wire logic        disable_cmd,
  input wire logic [1:0]  queue_state,
  input wire logic        enable_error,
  input wire logic [4:0]  xfer_limit,
  input wire logic        occ_irq_table_select,
  input wire logic [15:0] occ_irq_handle,
  input wire logic        pcie_ats_enable,
  input wire logic        pcie_prs_enable,
  // Descriptors and faults
  input wire logic        desc_valid,
  input wire logic [31:0] desc_xfer_size,
  input wire logic        res_valid,
  input wire logic        res_refused,
  input wire logic        res_use_ats,
  input wire logic        res_size_ok,
  input wire logic        page_fault,
  input wire logic        page_fault_blocking,
  input wire logic        fault_stop_report,
  input wire logic        fault_page_request
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  ////////////////////
  sequence s_drain_go;
    disable_cmd && queue_state == QSTATE_ENABLED;
  endsequence
  sequence s_plain_fault;
    page_fault && !(page_fault_blocking && pcie_prs_enable);
  endsequence
  // Wide compare, a limit of 31 must not wrap
  sequence s_too_long;
    desc_valid && ({1'h0, desc_xfer_size} > (33'h1 << xfer_limit));
  endsequence
  ////////////////////
  a_enable_two_cycles: assert property (
    $rose(queue_state == QSTATE_ENABLED) |-> $past(enable_cmd, 2))
    else $error("enabled without enable command");
  a_enable_fail_stays: assert property (
    $rose(enable_error) |-> queue_state == QSTATE_DISABLED
      && $past(enable_cmd, 2))
    else $error("enable error out of step");
  a_drain_follows: assert property (
    s_drain_go |=> queue_state == QSTATE_DRAINING)
    else $error("disable did not start draining");
  a_refused_unless_on: assert property (
    desc_valid |=> res_valid
      && res_refused == ($past(queue_state) != QSTATE_ENABLED))
    else $error("descriptor result wrong");
  a_ats_follows_pcie: assert property (
    desc_valid && !pcie_ats_enable |=> !res_use_ats)
    else $error("translation used while off");
  a_size_over_limit: assert property (
    s_too_long |=> !res_size_ok)
    else $error("oversize transfer accepted");
  a_fields_locked: assert property (
    queue_state != QSTATE_DISABLED |=> $stable(occ_irq_handle)
      && $stable(occ_irq_table_select) && $stable(xfer_limit))
    else $error("locked field changed");
  a_fault_stops: assert property (
    s_plain_fault |=> fault_stop_report && !fault_page_request)
    else $error("fault not stopped and reported");
  a_fault_quiet: assert property (
    !page_fault |=> !(fault_stop_report || fault_page_request))
    else $error("fault output without fault");
endmodule
`default_nettype wire

// file: dv/wqcf_top_bench.sv
// Self-checking bench for the queue configuration block
`timescale 1ns/1ns
`default_nettype none
module wqcf_top_bench
  import wqcf_pkg::*;
;
  // Clock, reset and register port
  logic        core_clk = 1'h0, arst_n = 1'h0;
  logic        reg_wr = 1'h0, reg_rd = 1'h0;
  logic [4:0]  reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  // Capabilities and PCIe enables, all but handle request granted at start
  logic        cap_prs_support = 1'h1, cap_ats_support = 1'h1;
  logic        cap_bof_support = 1'h1, cap_batch_support = 1'h1;
  logic        cap_occ_irq_support = 1'h1, cap_handle_request = 1'h0;
  logic [3:0]  cap_batch_max = 4'h5, batch_limit;
  logic [4:0]  cap_xfer_max = 5'h10, xfer_limit;
  logic        pcie_prs_enable = 1'h1, pcie_ats_enable = 1'h1;
  // Queue commands and settings in effect
  logic        enable_cmd = 1'h0, disable_cmd = 1'h0, drain_done = 1'h0;
  logic [1:0]  queue_state, enable_error_code;
  logic        enable_error, queue_dedicated, use_ats, use_prs;
  logic        occ_irq_table_select, occ_irq_handle_direct;
  logic [15:0] occ_irq_handle, desc_batch_count = 16'h0;
  // Descriptors and faults
  logic        desc_valid = 1'h0, desc_bof_flag = 1'h0;
  logic        desc_is_batch = 1'h0;
  logic [31:0] desc_xfer_size = 32'h0;
  logic        res_valid, res_refused, res_use_ats, res_fault_block;
  logic        res_size_ok, fault_stop_report, fault_page_request;
  logic        page_fault = 1'h0, page_fault_blocking = 1'h0;
  int          n_errors = 0, num_checks = 0;

  wqcf_top wqcf_top_inst (
    .core_clk, .arst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .cap_prs_support, .cap_ats_support, .cap_bof_support, .cap_batch_support,
    .cap_batch_max, .cap_xfer_max, .cap_occ_irq_support, .cap_handle_request,
    .pcie_prs_enable, .pcie_ats_enable, .enable_cmd, .disable_cmd,
    .drain_done, .queue_state, .enable_error, .enable_error_code,
    .queue_dedicated, .use_ats, .use_prs, .xfer_limit, .batch_limit,
    .occ_irq_table_select, .occ_irq_handle, .occ_irq_handle_direct,
    .desc_valid, .desc_bof_flag, .desc_is_batch, .desc_xfer_size,
    .desc_batch_count, .res_valid, .res_refused, .res_use_ats,
    .res_fault_block, .res_size_ok, .page_fault, .page_fault_blocking,
    .fault_stop_report, .fault_page_request
  );

  always #50 core_clk = ~core_clk;
  ////////////////////
  // Drive 1 ns after the edge so no race with the design's flops
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Trailing idle cycle keeps strobes from being raised twice in a step
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    tick();
    reg_wr = 1'h0;
    tick();
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
    reg_addr = a;
    reg_rd = 1'h1;
    tick();
    reg_rd = 1'h0;
    tick();
    chk(reg_rdata, exp);
  endtask
  task automatic caps(input logic v);
    cap_prs_support = v;
    cap_ats_support = v;
    cap_bof_support = v;
    cap_batch_support = v;
    cap_occ_irq_support = v;
    pcie_prs_enable = v;
  endtask
  task automatic en_q();
    enable_cmd = 1'h1;
    tick();
    enable_cmd = 1'h0;
    tick();
    tick();
  endtask
  task automatic desc(input logic bof, input logic bat, input logic [31:0] sz,
                      input logic [15:0] cnt, input logic [4:0] exp, m);
    desc_bof_flag = bof;
    desc_is_batch = bat;
    desc_xfer_size = sz;
    desc_batch_count = cnt;
    desc_valid = 1'h1;
    tick();
    desc_valid = 1'h0;
    chk(32'({res_valid, res_refused, res_use_ats, res_fault_block,
             res_size_ok} & m), 32'(exp));
    tick();
  endtask
  task automatic flt(input logic blk, input logic [1:0] exp);
    page_fault = 1'h1;
    page_fault_blocking = blk;
    tick();
    page_fault = 1'h0;
    chk(32'({fault_stop_report, fault_page_request}), 32'(exp));
    tick();
  endtask
  ////////////////////
  task automatic t_reserved();
    rdc(OFS_MODE_XLAT, 32'h0);
    rdc(OFS_SIZE_LIM, 32'h0);
    rdc(OFS_IRQ_ROUTE, 32'h0);
    chk(32'(queue_state), 32'(QSTATE_DISABLED));
    caps(1'h0);
    wr(OFS_MODE_XLAT, 32'hFFFF_FFFF);
    rdc(OFS_MODE_XLAT, 32'h1);
    wr(OFS_SIZE_LIM, 32'hFFFF_FFFF);
    rdc(OFS_SIZE_LIM, 32'h1F);
    wr(OFS_IRQ_ROUTE, 32'hFFFF_FFFF);
    rdc(OFS_IRQ_ROUTE, 32'h0);
    wr(5'h14, 32'hFFFF_FFFF);
    rdc(5'h14, 32'h0);
    caps(1'h1);
  endtask
  task automatic t_fields();
    wr(OFS_MODE_XLAT, 32'hD);
    rdc(OFS_MODE_XLAT, 32'hD);
    chk(32'({queue_dedicated, use_ats, use_prs}), 32'h4);
    wr(OFS_MODE_XLAT, 32'h3);
    rdc(OFS_MODE_XLAT, 32'h3);
    chk(32'({queue_dedicated, use_ats, use_prs}), 32'h7);
    pcie_prs_enable = 1'h0;
    tick();
    rdc(OFS_MODE_XLAT, 32'h1);
    pcie_prs_enable = 1'h1;
    wr(OFS_IRQ_ROUTE, 32'h1_ABCD);
    rdc(OFS_IRQ_ROUTE, 32'h1_ABCD);
    chk({15'h0, occ_irq_table_select, occ_irq_handle}, 32'h1_ABCD);
    chk(32'(occ_irq_handle_direct), 32'h1);
    cap_handle_request = 1'h1;
    tick();
    tick();
    chk(32'(occ_irq_handle_direct), 32'h0);
    wr(OFS_IRQ_ROUTE, 32'hBEEF);
    rdc(OFS_IRQ_ROUTE, 32'hBEEF);
  endtask
  task automatic t_enable_bad();
    logic [31:0] bad [3];
    logic [1:0]  code [3];
    bad = '{32'h71, 32'h05, 32'hC5};
    code = '{CHK_XFER_BAD, CHK_BATCH_BAD, CHK_BATCH_BAD};
    for (int i = 0; i < 3; i++) begin
      wr(OFS_SIZE_LIM, bad[i]);
      en_q();
      chk(32'({enable_error, enable_error_code}), {29'h1, code[i]});
      chk(32'(queue_state), 32'(QSTATE_DISABLED));
    end
  endtask
  task automatic t_enable_ok();
    wr(OFS_SIZE_LIM, 32'h65);
    en_q();
    chk(32'(queue_state), 32'(QSTATE_ENABLED));
    chk({23'h0, batch_limit, xfer_limit}, 32'h65);
    wr(OFS_MODE_XLAT, 32'h0);
    wr(OFS_SIZE_LIM, 32'h22);
    wr(OFS_IRQ_ROUTE, 32'h1_0001);
    rdc(OFS_MODE_XLAT, 32'h3);
    rdc(OFS_SIZE_LIM, 32'h65);
    rdc(OFS_IRQ_ROUTE, 32'hBEEF);
  endtask
  task automatic t_desc();
    desc(1'h1, 1'h0, 32'h20, 16'h0, 5'h17, 5'h1F);
    desc(1'h0, 1'h0, 32'h21, 16'h0, 5'h14, 5'h1F);
    desc(1'h0, 1'h1, 32'h20, 16'h8, 5'h15, 5'h1F);
    desc(1'h0, 1'h1, 32'h20, 16'h9, 5'h14, 5'h1F);
    pcie_ats_enable = 1'h0;
    desc(1'h1, 1'h0, 32'h1, 16'h0, 5'h13, 5'h1F);
    pcie_ats_enable = 1'h1;
    flt(1'h1, 2'h1);
    flt(1'h0, 2'h2);
    pcie_prs_enable = 1'h0;
    flt(1'h1, 2'h2);
    pcie_prs_enable = 1'h1;
  endtask
  task automatic t_drain();
    disable_cmd = 1'h1;
    tick();
    disable_cmd = 1'h0;
    chk(32'(queue_state), 32'(QSTATE_DRAINING));
    desc(1'h0, 1'h0, 32'h1, 16'h0, 5'h18, 5'h18);
    wr(OFS_IRQ_ROUTE, 32'h0);
    rdc(OFS_IRQ_ROUTE, 32'hBEEF);
    drain_done = 1'h1;
    tick();
    drain_done = 1'h0;
    chk(32'(queue_state), 32'(QSTATE_DISABLED));
    wr(OFS_IRQ_ROUTE, 32'h1_1234);
    rdc(OFS_IRQ_ROUTE, 32'h1_1234);
    wr(OFS_MODE_XLAT, 32'h9);
    rdc(OFS_MODE_XLAT, 32'h9);
    chk(32'(use_prs), 32'h0);
    en_q();
    flt(1'h1, 2'h2);
    desc(1'h1, 1'h0, 32'h1, 16'h0, 5'h15, 5'h1F);
  endtask
  ////////////////////
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    #1;
    arst_n = 1'h1;
    t_reserved();
    t_fields();
    t_enable_bad();
    t_enable_ok();
    t_desc();
    t_drain();
    print_verdict();
  end
  // Hang guard
  initial begin
    #10_000_000;
    n_errors++;
    print_verdict();
  end
endmodule

bind wqcf_top wqcf_top_asserts wqcf_top_asserts_inst (
  .core_clk, .arst_n, .enable_cmd, .disable_cmd, .queue_state,
  .enable_error, .xfer_limit, .occ_irq_table_select, .occ_irq_handle,
  .pcie_ats_enable, .pcie_prs_enable, .desc_valid, .desc_xfer_size,
  .res_valid, .res_refused, .res_use_ats, .res_size_ok, .page_fault,
  .page_fault_blocking, .fault_stop_report, .fault_page_request
);
`default_nettype wire
